// >>> logic/sal_defines.vh
`ifndef SAL_DEFINES_VH
`define SAL_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define SAL_ADDR_ALT_SELECT  8'h4f
`define SAL_ADDR_CTRL        8'h5f
`define SAL_ADDR_TX_LOW      8'h60
`define SAL_ADDR_TX_HIGH     8'h61
`define SAL_ADDR_RX_LOW      8'h62
`define SAL_ADDR_RX_HIGH     8'h63
`define SAL_ADDR_EVT_STATUS  8'hfb
`define SAL_ADDR_EVT_MASK    8'hfd
`define SAL_ADDR_EVT_CLEAR   8'hff

// ****************************************
// field positions
// ****************************************
`define SAL_CTRL_SINGLE_PIN  0
`define SAL_CTRL_DIR_SELECT  2
`define SAL_CTRL_LAUNCH      3
`define SAL_CTRL_AUTO_RX     4
`define SAL_CTRL_RX_FAULT    5
`define SAL_EVT_TIMEOUT      3
`define SAL_EVT_TX_DONE      4
`define SAL_EVT_RX_DONE      5
`define SAL_ALT_PIN_ZERO     0
`define SAL_ALT_PIN_SEVEN    7

// ****************************************
// reset values
// ****************************************
`define SAL_RST_BYTE         8'h00

// ****************************************
// timing
// ****************************************
`define SAL_CLK_MHZ          10
`define SAL_BIT_TIME_US      1000
`define SAL_TIMEOUT_MS       100
`define SAL_TX_BITS          14
`define SAL_RX_BITS          10

`endif

// >>> logic/sal_antenna_link.v
// Function
// - mode bit enables automatic reply listening
// - fourteen-bit transmit word in two registers
// - launch bit starts serial transmission when the direction bit is set
// - transmit done sets status flag
// - no reply in 100 ms means timeout
// - full reply sets receive-done flag
// - timeout sets timeout status flag
// - reply stored in two receive registers
// - receive error sets receive fault flag
// - shared pin zero may be antenna input
// - shared pin seven may be irq output
// - direction pin dedicated to antenna use
// - all pins are inputs in reset; two-pin default then drives the line pin
// - bit zero selects one or two pins
// - direction pin low receive, high transmit
// - unfinished reply also raises timeout
// - events reach irq only when unmasked
`timescale 1ns/1ps
`include "sal_defines.vh"
`default_nettype none

module sal_antenna_link #(
   parameter [19:0] BIT_CYCLES = `SAL_BIT_TIME_US * `SAL_CLK_MHZ,
   parameter [19:0] TIMEOUT_CYCLES = `SAL_TIMEOUT_MS * 1000 * `SAL_CLK_MHZ
) (
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // register port behind the host serial slave
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_rd,
   output reg [7:0] o_reg_rdata,
   // antenna line pin
   input wire i_antenna_line_pin,
   output reg o_antenna_line_pin,
   output reg o_antenna_line_pin_oe,
   // antenna direction pin
   output reg o_antenna_direction_pin,
   output reg o_antenna_direction_pin_oe,
   // shared pin zero, antenna input in two-pin mode
   input wire i_shared_pin_zero,
   // shared pin seven, host irq line
   output reg o_shared_pin_seven,
   output reg o_shared_pin_seven_oe
);

   // ****************************************
   // constants
   // ****************************************
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_TX = 3'd1;
   localparam [2:0] ST_WAIT = 3'd2;
   localparam [2:0] ST_RX_HIGH = 3'd3;
   localparam [2:0] ST_RX_LOW = 3'd4;

   localparam [19:0] ONE_HIGH = (BIT_CYCLES * 3) / 4;
   localparam [19:0] ZERO_HIGH = BIT_CYCLES / 4;
   localparam [19:0] RX_SPLIT = BIT_CYCLES / 2;
   localparam [19:0] RX_GAP = BIT_CYCLES * 2;

   // ****************************************
   // functions
   // ****************************************
   // write strobe for one register offset
   function hit;
      input [7:0] addr;
      input [7:0] target;
      input wr;
      begin
         hit = wr && (addr == target);
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   reg [7:0] alt_select;
   reg single_pin;
   reg dir_select;
   reg auto_rx;
   reg rx_fault;
   reg [13:0] tx_word;
   reg [9:0] rx_word;
   reg [9:0] rx_shift;
   reg evt_timeout;
   reg evt_tx_done;
   reg evt_rx_done;
   reg [7:0] evt_mask;
   reg [2:0] state;
   reg [19:0] cnt;
   reg [19:0] wait_cnt;
   reg [3:0] bit_cnt;
   reg sync1;
   reg sync2;
   reg sync3;
   reg rx_level;
   reg rx_prev;

   // per-cycle event strobes from the link machine
   reg set_timeout;
   reg set_tx_done;
   reg set_rx_done;
   reg set_fault;
   reg load_rx;

   wire wr_ctrl = hit(i_reg_addr, `SAL_ADDR_CTRL, i_reg_wr);
   wire wr_clear = hit(i_reg_addr, `SAL_ADDR_EVT_CLEAR, i_reg_wr);
   // transmit launch: launch bit with direction set to transmit
   wire start_tx = wr_ctrl && i_reg_wdata[`SAL_CTRL_LAUNCH] && i_reg_wdata[`SAL_CTRL_DIR_SELECT];
   // receive setup: direction zero and mode one
   wire start_rx = wr_ctrl && !i_reg_wdata[`SAL_CTRL_DIR_SELECT] && i_reg_wdata[`SAL_CTRL_AUTO_RX];
   wire tx_bit = tx_word[4'd13 - bit_cnt];
   wire [19:0] high_len = tx_bit ? ONE_HIGH : ZERO_HIGH;
   wire [7:0] status_byte = {2'b00, evt_rx_done, evt_tx_done, evt_timeout, 3'b000};
   wire [7:0] ctrl_byte = {2'b00, rx_fault, auto_rx, 1'b0, dir_select, 1'b0, single_pin};

   // ****************************************
   // input synchroniser
   // ****************************************
   // reply source: shared pin zero in two-pin mode
   wire rx_pin = single_pin ? i_antenna_line_pin : i_shared_pin_zero & alt_select[`SAL_ALT_PIN_ZERO];

   // three stages; level moves only when the last two agree
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         rx_level <= 1'b0;
         rx_prev <= 1'b0;
      end else begin
         sync1 <= rx_pin;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3) begin
            rx_level <= sync3;
         end
         rx_prev <= rx_level;
      end
   end

   // ****************************************
   // link state machine
   // ****************************************
   // pulse-width bits: long high is one, short high is zero
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         cnt <= 20'h00000;
         wait_cnt <= 20'h00000;
         bit_cnt <= 4'h0;
         rx_shift <= 10'h000;
         set_timeout <= 1'b0;
         set_tx_done <= 1'b0;
         set_rx_done <= 1'b0;
         set_fault <= 1'b0;
         load_rx <= 1'b0;
      end else begin
         set_timeout <= 1'b0;
         set_tx_done <= 1'b0;
         set_rx_done <= 1'b0;
         set_fault <= 1'b0;
         load_rx <= 1'b0;
         case (state)
            ST_IDLE: begin
               cnt <= 20'h00000;
               wait_cnt <= 20'h00000;
               bit_cnt <= 4'h0;
               if (start_tx) begin
                  state <= ST_TX;
               end else if (start_rx) begin
                  rx_shift <= 10'h000;
                  state <= ST_WAIT;
               end
            end
            ST_TX: begin
               // word sent msb first, one bit period each
               if (cnt == BIT_CYCLES - 20'h00001) begin
                  cnt <= 20'h00000;
                  if (bit_cnt == `SAL_TX_BITS - 1) begin
                     set_tx_done <= 1'b1;
                     bit_cnt <= 4'h0;
                     rx_shift <= 10'h000;
                     state <= auto_rx ? ST_WAIT : ST_IDLE;
                  end else begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end else begin
                  cnt <= cnt + 20'h00001;
               end
            end
            ST_WAIT: begin
               if (rx_level && !rx_prev) begin
                  cnt <= 20'h00000;
                  state <= ST_RX_HIGH;
               end else if (wait_cnt == TIMEOUT_CYCLES - 20'h00001) begin
                  set_timeout <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  wait_cnt <= wait_cnt + 20'h00001;
               end
            end
            ST_RX_HIGH: begin
               if (!rx_level) begin
                  // width decides the bit value
                  rx_shift <= {rx_shift[8:0], (cnt >= RX_SPLIT)};
                  bit_cnt <= bit_cnt + 4'h1;
                  cnt <= 20'h00000;
                  state <= ST_RX_LOW;
               end else if (cnt == RX_GAP) begin
                  // stuck-high line counts as unfinished reply
                  set_timeout <= 1'b1;
                  set_fault <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  cnt <= cnt + 20'h00001;
               end
            end
            ST_RX_LOW: begin
               if (bit_cnt == `SAL_RX_BITS) begin
                  set_rx_done <= 1'b1;
                  load_rx <= 1'b1;
                  state <= ST_IDLE;
               end else if (rx_level) begin
                  cnt <= 20'h00000;
                  state <= ST_RX_HIGH;
               end else if (cnt == RX_GAP) begin
                  set_timeout <= 1'b1;
                  set_fault <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  cnt <= cnt + 20'h00001;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   // software writes; hardware sets win over software clears
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alt_select <= `SAL_RST_BYTE;
         single_pin <= 1'b0;
         dir_select <= 1'b0;
         auto_rx <= 1'b0;
         rx_fault <= 1'b0;
         tx_word <= 14'h0000;
         rx_word <= 10'h000;
         evt_timeout <= 1'b0;
         evt_tx_done <= 1'b0;
         evt_rx_done <= 1'b0;
         evt_mask <= `SAL_RST_BYTE;
      end else begin
         if (hit(i_reg_addr, `SAL_ADDR_ALT_SELECT, i_reg_wr)) begin
            alt_select <= i_reg_wdata;
         end
         // direction, pin mode, mode; launch never stored
         if (wr_ctrl) begin
            single_pin <= i_reg_wdata[`SAL_CTRL_SINGLE_PIN];
            dir_select <= i_reg_wdata[`SAL_CTRL_DIR_SELECT];
            auto_rx <= i_reg_wdata[`SAL_CTRL_AUTO_RX];
         end
         // fault held until the next launch or listen write in idle
         if (set_fault) begin
            rx_fault <= 1'b1;
         end else if (state == ST_IDLE && (start_tx || start_rx)) begin
            rx_fault <= 1'b0;
         end
         // transmit word low and high bytes
         if (hit(i_reg_addr, `SAL_ADDR_TX_LOW, i_reg_wr)) begin
            tx_word[7:0] <= i_reg_wdata;
         end
         if (hit(i_reg_addr, `SAL_ADDR_TX_HIGH, i_reg_wr)) begin
            tx_word[13:8] <= i_reg_wdata[5:0];
         end
         // reply stored, hardware load wins over writes
         if (load_rx) begin
            rx_word <= rx_shift;
         end else begin
            if (hit(i_reg_addr, `SAL_ADDR_RX_LOW, i_reg_wr)) begin
               rx_word[7:0] <= i_reg_wdata;
            end
            if (hit(i_reg_addr, `SAL_ADDR_RX_HIGH, i_reg_wr)) begin
               rx_word[9:8] <= i_reg_wdata[1:0];
            end
         end
         if (hit(i_reg_addr, `SAL_ADDR_EVT_MASK, i_reg_wr)) begin
            evt_mask <= i_reg_wdata;
         end
         // timeout flag, write one to clear
         evt_timeout <= set_timeout | (evt_timeout & ~(wr_clear & i_reg_wdata[`SAL_EVT_TIMEOUT]));
         evt_tx_done <= set_tx_done | (evt_tx_done & ~(wr_clear & i_reg_wdata[`SAL_EVT_TX_DONE]));
         evt_rx_done <= set_rx_done | (evt_rx_done & ~(wr_clear & i_reg_wdata[`SAL_EVT_RX_DONE]));
      end
   end

   // registered read port; unmapped offsets read zero
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         if (i_reg_addr == `SAL_ADDR_ALT_SELECT) begin
            o_reg_rdata <= alt_select;
         end else if (i_reg_addr == `SAL_ADDR_CTRL) begin
            o_reg_rdata <= ctrl_byte;
         end else if (i_reg_addr == `SAL_ADDR_TX_LOW) begin
            o_reg_rdata <= tx_word[7:0];
         end else if (i_reg_addr == `SAL_ADDR_TX_HIGH) begin
            o_reg_rdata <= {2'b00, tx_word[13:8]};
         end else if (i_reg_addr == `SAL_ADDR_RX_LOW) begin
            o_reg_rdata <= rx_word[7:0];
         end else if (i_reg_addr == `SAL_ADDR_RX_HIGH) begin
            o_reg_rdata <= {6'h00, rx_word[9:8]};
         end else if (i_reg_addr == `SAL_ADDR_EVT_STATUS) begin
            o_reg_rdata <= status_byte;
         end else if (i_reg_addr == `SAL_ADDR_EVT_MASK) begin
            o_reg_rdata <= evt_mask;
         end else begin
            o_reg_rdata <= 8'h00;
         end
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************
   // all outputs registered so pins never glitch on decode
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // every pin starts as an input
         o_antenna_line_pin <= 1'b0;
         o_antenna_line_pin_oe <= 1'b0;
         o_antenna_direction_pin <= 1'b0;
         o_antenna_direction_pin_oe <= 1'b0;
         o_shared_pin_seven <= 1'b0;
         o_shared_pin_seven_oe <= 1'b0;
      end else begin
         // high for the coded width, low for the rest
         o_antenna_line_pin <= (state == ST_TX) && (cnt < high_len);
         // one pin released while listening; two pins keep it driven
         o_antenna_line_pin_oe <= !single_pin || (state == ST_TX);
         // direction pin high only while transmitting
         o_antenna_direction_pin <= (state == ST_TX);
         // direction pin driven only in single-pin mode
         o_antenna_direction_pin_oe <= single_pin;
         // masked events onto the irq line
         o_shared_pin_seven <= |(status_byte & evt_mask);
         // pin seven driven only when selected
         o_shared_pin_seven_oe <= alt_select[`SAL_ALT_PIN_SEVEN];
      end
   end

endmodule

`default_nettype wire

// >>> verif/sal_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checks for the antenna link
// ****************************************
module sal_link_properties #(
   parameter int BIT_CYCLES = 40
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   // pins
   input wire logic i_antenna_line_pin,
   input wire logic o_antenna_line_pin,
   input wire logic o_antenna_line_pin_oe,
   input wire logic o_antenna_direction_pin,
   input wire logic o_antenna_direction_pin_oe,
   input wire logic i_shared_pin_zero,
   input wire logic o_shared_pin_seven,
   input wire logic o_shared_pin_seven_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   localparam int Q = BIT_CYCLES / 4;
   int dir_cnt;
   int high_cnt;
   // run lengths kept in counters, long repetitions would choke the tools
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dir_cnt <= 0;
         high_cnt <= 0;
      end else begin
         dir_cnt <= o_antenna_direction_pin ? dir_cnt + 1 : 0;
         high_cnt <= o_antenna_line_pin ? high_cnt + 1 : 0;
      end
   end
   sequence s_ctrl_write;
      i_reg_wr && i_reg_addr == 8'h5f;
   endsequence
   sequence s_launch;
      s_ctrl_write ##0 (i_reg_wdata[3] && i_reg_wdata[2] && !o_antenna_direction_pin);
   endsequence
   sequence s_frame_open;
      ##2 (o_antenna_direction_pin && o_antenna_line_pin);
   endsequence
   AST_PINS_IN_RESET: assert property (disable iff (1'b0) !i_rst_n |->
      !o_antenna_line_pin_oe && !o_antenna_direction_pin_oe && !o_shared_pin_seven_oe) else $error("pin driven in reset");
   AST_LAUNCH_OPENS_FRAME: assert property (s_launch |-> s_frame_open) else $error("launch did not start frame");
   AST_FRAME_STARTS_HIGH: assert property ($rose(o_antenna_direction_pin) |-> o_antenna_line_pin) else
      $error("frame not opened by a high pulse");
   AST_TX_DRIVES_LINE: assert property (o_antenna_direction_pin |-> o_antenna_line_pin_oe) else
      $error("line released while transmitting");
   AST_FRAME_LENGTH: assert property ($fell(o_antenna_direction_pin) |->
      dir_cnt inside {[14 * BIT_CYCLES - 2 : 14 * BIT_CYCLES + 2]}) else $error("transmit frame length wrong");
   AST_PULSE_WIDTH: assert property ($fell(o_antenna_line_pin) && o_antenna_direction_pin |->
      high_cnt inside {[Q - 1 : Q + 1], [3 * Q - 1 : 3 * Q + 1]}) else $error("pulse width wrong");
   AST_IRQ_PIN_SELECT: assert property (i_reg_wr && i_reg_addr == 8'h4f |=> ##1
      o_shared_pin_seven_oe == $past(i_reg_wdata[7], 2)) else $error("irq pin enable wrong");
   AST_SINGLE_PIN_SELECT: assert property (s_ctrl_write |=> ##1
      o_antenna_direction_pin_oe == $past(i_reg_wdata[0], 2)) else $error("direction pin enable wrong");
   AST_LAUNCH_READS_ZERO: assert property (i_reg_rd && i_reg_addr == 8'h5f |-> ##[1:2] !o_reg_rdata[3]) else
      $error("launch bit read as one");
endmodule
bind sal_antenna_link sal_link_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .i_antenna_line_pin(i_antenna_line_pin), .o_antenna_line_pin(o_antenna_line_pin),
   .o_antenna_line_pin_oe(o_antenna_line_pin_oe), .o_antenna_direction_pin(o_antenna_direction_pin),
   .o_antenna_direction_pin_oe(o_antenna_direction_pin_oe), .i_shared_pin_zero(i_shared_pin_zero),
   .o_shared_pin_seven(o_shared_pin_seven), .o_shared_pin_seven_oe(o_shared_pin_seven_oe));
`default_nettype wire

// >>> verif/sal_antenna_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// antenna controller stand-in
// ****************************************
module sal_antenna_model #(
   parameter int BIT = 40
) (
   // clock and line
   input wire logic i_clk,
   input wire logic i_line,
   // reply setup
   input wire logic [9:0] i_reply,
   input wire logic [15:0] i_gap,
   input wire logic [3:0] i_bits,
   // reply drive and decoded word
   output logic o_drive,
   output logic o_oe,
   output logic [13:0] o_word
);
   int w;
   int b;
   initial begin
      o_drive = 1'b0;
      o_oe = 1'b0;
      o_word = 14'h0000;
   end
   // decode a word, then answer; fewer than ten bits leaves a broken reply
   always begin
      for (b = 0; b < 14; b++) begin
         @(posedge i_line);
         w = 0;
         while (i_line) begin
            @(posedge i_clk);
            w++;
         end
         o_word = {o_word[12:0], w >= BIT / 2};
      end
      repeat (i_gap) @(posedge i_clk);
      for (b = 0; b < i_bits; b++) begin
         o_oe = 1'b1;
         o_drive = 1'b1;
         repeat (i_reply[9 - b] ? 3 * BIT / 4 : BIT / 4) @(posedge i_clk);
         o_drive = 1'b0;
         repeat (i_reply[9 - b] ? BIT / 4 : 3 * BIT / 4) @(posedge i_clk);
      end
      o_oe = 1'b0;
   end
endmodule
`default_nettype wire

// >>> verif/smart_antenna_control_link_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// antenna link bench
// ****************************************
module smart_antenna_control_link_bench;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic line_o, line_oe, dir, dir_oe, irq, irq_oe, ant_drive, ant_oe;
   logic [13:0] word;
   logic [9:0] reply = 10'h2d5;
   logic [15:0] gap = 16'd100;
   logic [3:0] nbits = 4'd10;
   int errors = 0, num_checks = 0;
   // register rows: offset, write value, value read back
   logic [23:0] rows [7] = '{24'h4f8181, 24'h60bcbc, 24'h612a2a, 24'hfd3838, 24'hfbff00, 24'h705500, 24'h5f0101};
   // released lines fall to the pull-down
   wire line = line_oe ? line_o : (ant_oe ? ant_drive : 1'b0);
   wire pin0 = ant_oe ? ant_drive : 1'b0;
   always #50 clk = ~clk;
   sal_antenna_link #(.BIT_CYCLES(20'd40), .TIMEOUT_CYCLES(20'd2000)) dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_antenna_line_pin(line), .o_antenna_line_pin(line_o), .o_antenna_line_pin_oe(line_oe),
      .o_antenna_direction_pin(dir), .o_antenna_direction_pin_oe(dir_oe), .i_shared_pin_zero(pin0),
      .o_shared_pin_seven(irq), .o_shared_pin_seven_oe(irq_oe));
   sal_antenna_model #(.BIT(40)) ant (.i_clk(clk), .i_line(line), .i_reply(reply), .i_gap(gap), .i_bits(nbits),
      .o_drive(ant_drive), .o_oe(ant_oe), .o_word(word));
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rreg(logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // poll a status bit, bounded well past the reply window
   task automatic wait_flag(int b);
      logic [7:0] s;
      for (int n = 0; n < 1500; n++) begin
         rreg(8'hfb, s);
         if (s[b] === 1'b1) break;
      end
      chk("status flag", 16'h0001, 16'(s[b]));
   endtask
   task automatic end_of_test;
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin : main
      logic [7:0] s;
      repeat (3) @(negedge clk);
      chk("pins in reset", 16'h0000, 16'({line_oe, dir_oe, irq_oe}));
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         rreg(rows[i][23:16], s);
         chk("reset value", 16'h0000, 16'(s));
         wreg(rows[i][23:16], rows[i][15:8]);
         rreg(rows[i][23:16], s);
         chk("register", 16'(rows[i][7:0]), 16'(s));
      end
      // single pin transmit with prompt reply, then a clear
      wreg(8'h5f, 8'h1d);
      wait_flag(4);
      chk("sent word", 16'h2abc, 16'(word));
      chk("irq", 16'h0001, 16'(irq));
      rreg(8'h5f, s);
      chk("launch bit", 16'h0000, 16'(s[3]));
      wait_flag(5);
      rreg(8'h62, s);
      chk("reply low", 16'h00d5, 16'(s));
      rreg(8'h63, s);
      chk("reply high", 16'h0002, 16'(s[1:0]));
      rreg(8'h5f, s);
      chk("fault", 16'h0000, 16'(s[5]));
      wreg(8'hff, 8'h38);
      rreg(8'hfb, s);
      chk("cleared", 16'h0000, 16'({s[5:3], irq}));
      // silent antenna with the timeout event masked
      wreg(8'hfd, 8'h30);
      nbits = 4'd0;
      wreg(8'h5f, 8'h1d);
      wait_flag(3);
      wreg(8'hff, 8'h10);
      rreg(8'hfb, s);
      chk("no reply", 16'h0008, 16'({s[5:3], 3'b000}));
      chk("masked irq", 16'h0000, 16'(irq));
      // slow reply broken after four bits
      wreg(8'hff, 8'h38);
      nbits = 4'd4;
      gap = 16'd1500;
      wreg(8'h5f, 8'h1d);
      wait_flag(3);
      rreg(8'h5f, s);
      chk("fault", 16'h0001, 16'(s[5]));
      // two pin mode, reply on shared pin zero
      wreg(8'hff, 8'h38);
      nbits = 4'd10;
      gap = 16'd100;
      reply = 10'h155;
      wreg(8'h5f, 8'h1c);
      // pin enable follows the stored mode bit one edge later
      @(negedge clk);
      chk("direction enable", 16'h0000, 16'(dir_oe));
      wait_flag(5);
      rreg(8'h62, s);
      chk("two pin reply", 16'h0055, 16'(s));
      rreg(8'h5f, s);
      chk("fault cleared", 16'h0000, 16'(s[5]));
      // direct listen with a silent antenna: zero word, no fault
      wreg(8'hff, 8'h38);
      wreg(8'h62, 8'h00);
      wreg(8'h63, 8'h00);
      wreg(8'h5f, 8'h11);
      wait_flag(3);
      rreg(8'h62, s);
      chk("listen word", 16'h0000, 16'(s));
      rreg(8'h5f, s);
      chk("listen fault", 16'h0000, 16'(s[5]));
      end_of_test();
   end
   // watchdog sized for roughly six times the expected run
   initial begin
      #6000000;
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
